/* File: hw/sdi_port.sv */
// Serial input port of a 12-bit voltage-output converter.
// Assumes frame select, serial clock and data come from pins, asynchronous to i_clk.
`timescale 1ns/10ps
`include "sdi_consts.svh"
module sdi_port (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_frame_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic i_apply_ready,
    output logic o_word_room,
    output sdi_pkg::sdi_code_t o_code,
    output sdi_pkg::sdi_mode_t o_power_mode,
    output logic o_amp_on,
    output logic o_pd_1k,
    output logic o_pd_100k,
    output logic o_out_hiz
);
    import sdi_pkg::*;

    logic [1:0] frame_sync_reg;
    logic [2:0] sclk_sync_reg;
    logic [1:0] din_sync_reg;
    logic frame_s;
    logic sclk_fall;
    logic din_s;
    sdi_state_t state_reg;
    logic [3:0] hi_cnt_reg;
    logic [3:0] edge_cnt_reg;
    logic [`SDI_WORD_BITS-1:0] shift_reg;
    logic [`SDI_WORD_BITS-1:0] shift_next;
    logic push_reg;
    logic [`SDI_FIFO_WIDTH-1:0] push_data_reg;
    logic last_edge;
    logic apply;
    sdi_code_t code_reg;
    sdi_mode_t mode_reg;
    logic amp_on_reg;
    logic pd_1k_reg;
    logic pd_100k_reg;
    logic out_hiz_reg;

    sdi_word_if #(.WIDTH(`SDI_FIFO_WIDTH)) wr_ch ();
    sdi_word_if #(.WIDTH(`SDI_FIFO_WIDTH)) rd_ch ();

    sdi_fifo #(.WIDTH(`SDI_FIFO_WIDTH), .DEPTH(`SDI_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .wr(wr_ch.snk),
        .rd(rd_ch.src)
    );

    // Pins pass two flops; the third sclk stage only feeds edge finding
    // Reset low: frame must really be seen high, and no false sclk fall follows reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            frame_sync_reg <= 2'h0;
            sclk_sync_reg <= 3'h0;
            din_sync_reg <= 2'h0;
        end else begin
            frame_sync_reg <= {frame_sync_reg[0], i_frame_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
            din_sync_reg <= {din_sync_reg[0], i_din};
        end
    end

    assign frame_s = frame_sync_reg[1];
    assign din_s = din_sync_reg[1];
    assign sclk_fall = sclk_sync_reg[2] && !sclk_sync_reg[1];
    assign shift_next = {shift_reg[`SDI_WORD_BITS-2:0], din_s};
    assign last_edge = (state_reg == SDI_ST_SHIFT) && !frame_s && sclk_fall
        && (edge_cnt_reg == `SDI_LAST_EDGE);

    // High time of frame select, counted in clocks before re-arming
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !frame_s) begin
            hi_cnt_reg <= 4'h0;
        end else if (hi_cnt_reg != 4'hf) begin
            hi_cnt_reg <= hi_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_reg <= SDI_ST_WAIT_HIGH;
        end else begin
            case (state_reg)
                SDI_ST_WAIT_HIGH: begin
                    if (frame_s && hi_cnt_reg >= 4'(`SDI_FRAME_HIGH_CYC - 1)) begin
                        state_reg <= SDI_ST_ARMED;
                    end
                end
                SDI_ST_ARMED: begin
                    // Stalls while the buffer is full; one frame needs one free slot
                    if (!frame_s && wr_ch.ready) begin
                        state_reg <= SDI_ST_SHIFT;
                    end
                end
                SDI_ST_SHIFT: begin
                    if (frame_s) begin
                        state_reg <= SDI_ST_WAIT_HIGH;
                    end else if (last_edge) begin
                        state_reg <= SDI_ST_DONE;
                    end
                end
                SDI_ST_DONE: begin
                    if (frame_s) begin
                        state_reg <= SDI_ST_WAIT_HIGH;
                    end
                end
                default: begin
                    state_reg <= SDI_ST_WAIT_HIGH;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            shift_reg <= '0;
            edge_cnt_reg <= 4'h0;
        end else if (state_reg != SDI_ST_SHIFT || frame_s) begin
            if (state_reg != SDI_ST_DONE) begin
                shift_reg <= '0;
                edge_cnt_reg <= 4'h0;
            end
        end else if (sclk_fall) begin
            shift_reg <= shift_next;
            edge_cnt_reg <= edge_cnt_reg + 4'h1;
        end
    end

    // Top two bits dropped; mode and code go to the buffer
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            push_reg <= 1'b0;
            push_data_reg <= '0;
        end else begin
            push_reg <= last_edge;
            if (last_edge) begin
                push_data_reg <= shift_next[`SDI_MODE_HI:0];
            end
        end
    end

    assign wr_ch.valid = push_reg;
    assign wr_ch.data = push_data_reg;
    assign rd_ch.ready = i_apply_ready;
    assign apply = rd_ch.valid && i_apply_ready;
    assign o_word_room = wr_ch.ready;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            code_reg <= `SDI_CODE_RST;
            mode_reg <= `SDI_MODE_RST;
        end else if (apply) begin
            code_reg <= rd_ch.data[`SDI_CODE_BITS-1:0];
            mode_reg <= rd_ch.data[`SDI_MODE_HI:`SDI_MODE_LO];
        end
    end

    // Power-down only switches the output stage; the code still loads from the word
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            amp_on_reg <= 1'b1;
            pd_1k_reg <= 1'b0;
            pd_100k_reg <= 1'b0;
            out_hiz_reg <= 1'b0;
        end else if (apply) begin
            amp_on_reg <= 1'b0;
            pd_1k_reg <= 1'b0;
            pd_100k_reg <= 1'b0;
            out_hiz_reg <= 1'b0;
            case (rd_ch.data[`SDI_MODE_HI:`SDI_MODE_LO])
                `SDI_MODE_NORMAL: amp_on_reg <= 1'b1;
                `SDI_MODE_PD_1K: pd_1k_reg <= 1'b1;
                `SDI_MODE_PD_100K: pd_100k_reg <= 1'b1;
                default: out_hiz_reg <= 1'b1;
            endcase
        end
    end

    // Unsigned code straight to the resistor string tap
    assign o_code = code_reg;
    assign o_power_mode = mode_reg;
    assign o_amp_on = amp_on_reg;
    assign o_pd_1k = pd_1k_reg;
    assign o_pd_100k = pd_100k_reg;
    assign o_out_hiz = out_hiz_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence seq_bit_edge;
        state_reg == SDI_ST_SHIFT && !frame_s && sclk_fall;
    endsequence
    sequence seq_last_edge;
        seq_bit_edge ##0 edge_cnt_reg == `SDI_LAST_EDGE;
    endsequence

    AST_BIT_CAPTURE: assert property (seq_bit_edge |=> shift_reg[0] == $past(din_s))
        else $error("serial bit not captured");
    AST_PUSH_ON_LAST: assert property (seq_last_edge |=> push_reg && state_reg == SDI_ST_DONE)
        else $error("word not executed on last edge");
    AST_PUSH_ONLY_LAST: assert property (push_reg |-> $past(edge_cnt_reg) == `SDI_LAST_EDGE)
        else $error("word executed early");
    AST_WORD_LAYOUT: assert property (push_reg |-> push_data_reg == shift_reg[`SDI_MODE_HI:0])
        else $error("pushed word layout wrong");
    AST_CODE_LOAD: assert property (apply |=> code_reg == $past(rd_ch.data[11:0]) ##0 o_code == code_reg)
        else $error("code register not loaded");
    AST_ABORT: assert property (state_reg == SDI_ST_SHIFT && frame_s |=> state_reg == SDI_ST_WAIT_HIGH && shift_reg == '0 && !push_reg)
        else $error("aborted frame not cleared");
    AST_HIZ_DECODE: assert property (apply && rd_ch.data[13:12] == 2'h3 |=> out_hiz_reg && !amp_on_reg && !pd_1k_reg && !pd_100k_reg)
        else $error("high-Z mode decode wrong");
    AST_1K_DECODE: assert property (apply && rd_ch.data[13:12] == 2'h1 |=> pd_1k_reg && !amp_on_reg && !out_hiz_reg)
        else $error("1k mode decode wrong");
    AST_RESET_ZERO: assert property (disable iff (1'b0) !i_resetn |=> code_reg == 12'h000 && mode_reg == 2'h0 && amp_on_reg)
        else $error("code not cleared by reset");
    AST_DONE_IGNORES: assert property (state_reg == SDI_ST_DONE && !frame_s |=> state_reg == SDI_ST_DONE && $stable(shift_reg) && !push_reg)
        else $error("edges not ignored after execution");
endmodule // sdi_port

/* File: hw/sdi_consts.svh */
// Constants of the serial converter input port.
// Assumes inclusion by bare name from design files under hw/.
`ifndef SDI_CONSTS_SVH
`define SDI_CONSTS_SVH

`define SDI_WORD_BITS 16
`define SDI_CODE_BITS 12
`define SDI_MODE_HI 13
`define SDI_MODE_LO 12
`define SDI_LAST_EDGE 4'hf
`define SDI_CODE_RST 12'h000
`define SDI_MODE_RST 2'h0
`define SDI_MODE_NORMAL 2'h0
`define SDI_MODE_PD_1K 2'h1
`define SDI_MODE_PD_100K 2'h2
`define SDI_MODE_HIZ 2'h3
`define SDI_CODE_SPAN 4096
`define SDI_CLK_NS 50
`define SDI_FRAME_HIGH_NS 33
`define SDI_FRAME_HIGH_CYC_RAW ((`SDI_FRAME_HIGH_NS + `SDI_CLK_NS - 1) / `SDI_CLK_NS)
`define SDI_FRAME_HIGH_CYC ((`SDI_FRAME_HIGH_CYC_RAW < 1) ? 1 : `SDI_FRAME_HIGH_CYC_RAW)
`define SDI_FIFO_WIDTH 14
`define SDI_FIFO_DEPTH 8

`endif

/* File: hw/sdi_pkg.sv */
// Types of the serial converter input port.
// Assumes nothing beyond the constants header.
package sdi_pkg;
    typedef logic [11:0] sdi_code_t;
    typedef logic [1:0] sdi_mode_t;
    typedef enum {SDI_ST_WAIT_HIGH, SDI_ST_ARMED, SDI_ST_SHIFT, SDI_ST_DONE} sdi_state_t;
endpackage

/* File: hw/sdi_word_if.sv */
// Valid/ready word channel between port logic and its word buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface sdi_word_if #(parameter int WIDTH = 14);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: hw/sdi_fifo.sv */
// Word buffer with a registered output stage.
// Assumes a single clock and synchronous active-low reset.
`timescale 1ns/10ps
module sdi_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    sdi_word_if.snk wr,
    sdi_word_if.src rd
);
    import sdi_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [AW:0] cnt_reg;
    logic out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic push;
    logic load;

    assign wr.ready = (cnt_reg != FULL);
    assign push = wr.valid && wr.ready;
    // Refill the output stage whenever it is empty or being taken
    assign load = (cnt_reg != '0) && (!out_valid_reg || rd.ready);
    assign rd.valid = out_valid_reg;
    assign rd.data = out_data_reg;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wptr_reg] <= wr.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wptr_reg <= wptr_reg + 1'b1;
            end
            if (load) begin
                rptr_reg <= rptr_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (load) begin
            out_valid_reg <= 1'b1;
            out_data_reg <= mem[rptr_reg];
        end else if (rd.ready) begin
            out_valid_reg <= 1'b0;
        end
    end
endmodule // sdi_fifo

/* File: dv/sdi_host.sv */
// Host-side serial master model driving the converter port pins.
// Assumes the bench pulses i_go for one cycle and waits for o_busy to drop.
`timescale 1ns/10ps
module sdi_host (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [19:0] i_word,
    input wire logic [4:0] i_nbits,
    output logic o_busy,
    output logic o_frame_n,
    output logic o_sclk,
    output logic o_din
);
    int i;
    initial begin
        o_busy = 1'b0;
        o_frame_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                // Offset keeps pin edges away from the sampling edge
                #13;
                o_busy = 1'b1;
                o_frame_n = 1'b1;
                #150;
                o_frame_n = 1'b0;
                #200;
                for (i = int'(i_nbits) - 1; i >= 0; i--) begin
                    o_sclk = 1'b1;
                    o_din = i_word[i];
                    #200;
                    o_sclk = 1'b0;
                    #200;
                end
                // Released data line must not keep the last bit
                o_din = ~o_din;
                if (i_nbits < 5'd16) begin
                    o_frame_n = 1'b1;
                    #150;
                end
                o_frame_n = 1'b0;
                o_busy = 1'b0;
            end
        end
    end
endmodule // sdi_host

/* File: dv/tb_top.sv */
// Self-checking bench of the serial converter input port.
// Assumes the host model in dv/ and the design files under hw/.
`timescale 1ns/10ps
`define CHK(a, b) \
    compares++; \
    if ((a) !== (b)) begin \
        error_cnt++; \
        $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); \
    end
module tb_top;
    import sdi_pkg::*;
    logic i_clk, i_resetn, i_apply_ready, go, busy, frame_n, sclk, din;
    logic o_word_room, o_amp_on, o_pd_1k, o_pd_100k, o_out_hiz;
    sdi_code_t o_code;
    sdi_mode_t o_power_mode;
    logic [19:0] word;
    logic [4:0] nbits;
    logic [13:0] exp_q[$];
    logic [13:0] last_exp, last_seen, e;
    int error_cnt, compares, cyc, n;
    integer seed = 32'hf33c8f85;

    sdi_port u_sdi_port (.i_clk(i_clk), .i_resetn(i_resetn), .i_frame_n(frame_n),
        .i_sclk(sclk), .i_din(din), .i_apply_ready(i_apply_ready),
        .o_word_room(o_word_room), .o_code(o_code), .o_power_mode(o_power_mode),
        .o_amp_on(o_amp_on), .o_pd_1k(o_pd_1k), .o_pd_100k(o_pd_100k), .o_out_hiz(o_out_hiz));
    sdi_host u_sdi_host (.i_clk(i_clk), .i_go(go), .i_word(word), .i_nbits(nbits),
        .o_busy(busy), .o_frame_n(frame_n), .o_sclk(sclk), .o_din(din));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task end_sim;
        $display("Errors: %0d, compares: %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task send(input logic [19:0] w, input logic [4:0] nb);
        int k;
        @(negedge i_clk);
        word = w;
        nbits = nb;
        go = 1'b1;
        @(negedge i_clk);
        go = 1'b0;
        for (k = 0; k < 2000 && busy; k++) @(negedge i_clk);
    endtask

    // Consecutive notes must differ, else the monitor sees no update
    task write_word(input logic [1:0] m, input logic [11:0] c, input logic extra);
        logic [1:0] x;
        x = 2'($random(seed));
        if ({m, c} === last_exp) c = ~c;
        exp_q.push_back({m, c});
        last_exp = {m, c};
        send(extra ? {x, m, c, 4'h5} : {4'h0, x, m, c}, extra ? 5'd20 : 5'd16);
    endtask

    task settle;
        int k;
        for (k = 0; k < 300 && exp_q.size() != 0; k++) @(negedge i_clk);
        repeat (20) @(negedge i_clk);
        `CHK(exp_q.size(), 0)
        `CHK({o_power_mode, o_code}, last_exp)
    endtask

    always @(negedge i_clk) begin
        if (i_resetn && ({o_power_mode, o_code} !== last_seen)) begin
            last_seen = {o_power_mode, o_code};
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("Error at %0t: unexpected output update", $time);
            end else begin
                e = exp_q.pop_front();
                `CHK(last_seen, e)
                `CHK({o_out_hiz, o_pd_100k, o_pd_1k, o_amp_on}, 4'h1 << e[13:12])
            end
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("Error at %0t: run did not finish in time", $time);
            end_sim();
        end
    end

    initial begin
        i_resetn = 1'b0;
        i_apply_ready = 1'b1;
        go = 1'b0;
        word = 20'h0;
        nbits = 5'd16;
        last_exp = 14'h0;
        last_seen = 14'h0;
        repeat (4) @(negedge i_clk);
        `CHK({o_power_mode, o_code}, 14'h0)
        `CHK({o_out_hiz, o_pd_100k, o_pd_1k, o_amp_on, o_word_room}, 5'h03)
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clk);
        // Every mode, plus full-scale and zero codes
        for (n = 0; n < 8; n++) begin
            write_word(2'(n), (n == 4) ? 12'hfff : (n == 5) ? 12'h000 : 12'($random(seed)), 1'b0);
        end
        settle();
        // Short frames of every odd length must change nothing
        for (n = 1; n < 16; n += 2) send(20'($random(seed)), 5'(n));
        settle();
        // Extra edges after the 16th are ignored
        write_word(2'h2, 12'h5a5, 1'b1);
        settle();
        // Mid-run reset clears code and mode again
        i_resetn = 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK({o_power_mode, o_code}, 14'h0)
        `CHK({o_out_hiz, o_pd_100k, o_pd_1k, o_amp_on, o_word_room}, 5'h03)
        last_seen = 14'h0;
        last_exp = 14'h0;
        i_resetn = 1'b1;
        repeat (4) @(negedge i_clk);
        // Fill the buffer with the drain stalled
        i_apply_ready = 1'b0;
        for (n = 0; n < 12 && o_word_room; n++) begin
            write_word(2'($random(seed)), 12'($random(seed)), 1'b0);
            repeat (10) @(negedge i_clk);
        end
        `CHK(n, 9)
        `CHK(o_word_room, 1'b0)
        `CHK(exp_q.size(), 9)
        // Drain with random stalls; order must hold
        for (n = 0; n < 400 && exp_q.size() != 0; n++) begin
            @(negedge i_clk);
            i_apply_ready = 1'($random(seed));
        end
        i_apply_ready = 1'b1;
        settle();
        `CHK(o_word_room, 1'b1)
        end_sim();
    end
endmodule // tb_top
